// file: shared/cfgkp_pkg.sv
package cfgkp_pkg;
  // Access keys written to the configuration port
  localparam logic [7:0]  KEY_UNLOCK       = 8'h55;
  localparam logic [7:0]  KEY_LOCK         = 8'hAA;
  // Port base chosen by the strap
  localparam logic [15:0] BASE_STRAP0      = 16'h002E;
  localparam logic [15:0] BASE_STRAP1      = 16'h004E;
  localparam logic [15:0] DATA_PORT_OFS    = 16'h0001;
  // Global register indices
  localparam logic [7:0]  IDX_CFG_CTRL     = 8'h02;
  localparam logic [7:0]  IDX_LDN          = 8'h07;
  localparam logic [7:0]  IDX_DEV_ID       = 8'h20;
  localparam logic [7:0]  IDX_DEV_REV      = 8'h21;
  localparam logic [7:0]  IDX_PWR_CTRL     = 8'h22;
  localparam logic [7:0]  IDX_PWR_MGMT     = 8'h23;
  localparam logic [7:0]  IDX_OSC          = 8'h24;
  localparam logic [7:0]  IDX_BASE_LO      = 8'h26;
  localparam logic [7:0]  IDX_BASE_HI      = 8'h27;
  localparam logic [7:0]  IDX_LD_FIRST     = 8'h30;
  // Logical device register indices
  localparam logic [7:0]  IDX_ACTIVATE     = 8'h30;
  localparam logic [7:0]  IDX_LDWIN_BASE   = 8'h60;
  localparam int          LDWIN_AW         = 5;
  // Field positions and reset values
  localparam int          SOFT_RST_BIT     = 0;
  localparam int          ACTIVATE_BIT     = 0;
  localparam logic [7:0]  OSC_RST          = 8'h44;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  // Host blanking after core power-on reset
  localparam int          CLK_HZ           = 200_000_000;
  localparam int          POR_BLANK_US     = 500;
  localparam int          POR_BLANK_CYC    = (POR_BLANK_US * (CLK_HZ / 1_000_000));
  // Access state
  typedef enum logic {CFGKP_RUN, CFGKP_CFG} cfgkp_state_t;
endpackage : cfgkp_pkg

// file: logic/cfgkp_top.sv
// Notes on behaviour
// - Hard reset or core power-on reset leaves run state with every logical device off.
// - Index and data ports act only in configuration state; in run state only the unlock key written at the base is taken.
// - The base strap is caught at the falling edge of hard reset or at the end of power-on blanking.
// - Strap zero puts the port at 0x02E and strap one at 0x04E.
// - The port base can be rewritten through its low and high byte global registers.
// - Writing 0x55 to the port in run state enters configuration state.
// - Writing 0xAA to the port in configuration state returns to run state.
// - In configuration state the index port is at the base and the data port at base plus one.
// - The host then writes a register index and data accesses reach that register.
// - Global registers are reached by index and data without a device selection.
// - Only run and configuration states exist and run state takes the unlock key outside hard reset and power-on blanking.
// - All host accesses are ignored for 500 us after core power-on reset.
// - Writing one to bit 0 of the control register soft resets the device number, power control and all logical device registers.
module cfgkp_top #(
  parameter int          NUM_LD        = 10,
  parameter int          BLANK_CYC     = cfgkp_pkg::POR_BLANK_CYC,
  parameter logic [7:0]  DEV_ID_VAL    = 8'hA5, // Arbitrary value
  parameter logic [7:0]  DEV_REV_VAL   = 8'h01  // Arbitrary value
) (
  // Clock and core power-on reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // Board pins
  input  wire logic              hard_rst_n_i,
  input  wire logic              base_strap_i,
  // Host I/O cycles
  input  wire logic              io_wr_i,
  input  wire logic              io_rd_i,
  input  wire logic [15:0]       io_addr_i,
  input  wire logic [7:0]        io_wdata_i,
  output logic                   io_ack_o,
  output logic [7:0]             io_rdata_o,
  // Configuration state
  output logic                   cfg_mode_o,
  output logic [15:0]            cfg_base_o,
  output logic [NUM_LD-1:0]      ld_active_o
);
  localparam int LDW = (NUM_LD > 1) ? $clog2(NUM_LD) : 1;
  localparam int CW  = $clog2(BLANK_CYC + 1);
  localparam int WN  = 2 ** cfgkp_pkg::LDWIN_AW;

  // Pin synchronisers
  logic [2:0] hrst_sync_reg;
  logic [2:0] strap_sync_reg;
  logic       hrst_lvl_reg;
  logic       strap_lvl_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hrst_sync_reg  <= 3'b111;
      strap_sync_reg <= 3'b000;
      hrst_lvl_reg   <= 1'b1;
      strap_lvl_reg  <= 1'b0;
    end else begin
      hrst_sync_reg  <= {hrst_sync_reg[1:0], hard_rst_n_i};
      strap_sync_reg <= {strap_sync_reg[1:0], base_strap_i};
      if (hrst_sync_reg[1] == hrst_sync_reg[2]) begin
        hrst_lvl_reg <= hrst_sync_reg[2];
      end
      if (strap_sync_reg[1] == strap_sync_reg[2]) begin
        strap_lvl_reg <= strap_sync_reg[2];
      end
    end
  end

  // Configuration state
  cfgkp_pkg::cfgkp_state_t state_reg, state_next;
  logic [CW-1:0]  blank_reg, blank_next;
  logic           strap_cap_reg, strap_cap_next;
  logic           hrst_prev_reg;
  logic [15:0]    base_reg, base_next;
  logic [7:0]     index_reg, index_next;
  logic [7:0]     ldn_reg, ldn_next;
  logic [7:0]     pwr_ctrl_reg, pwr_ctrl_next;
  logic [7:0]     pwr_mgmt_reg, pwr_mgmt_next;
  logic [7:0]     osc_reg, osc_next;
  logic [7:0]     act_reg [NUM_LD];
  logic [7:0]     act_next [NUM_LD];
  logic [7:0]     win_reg [NUM_LD][WN];
  logic [7:0]     win_next [NUM_LD][WN];
  logic           ack_next;
  logic [7:0]     rdata_next;
  logic [NUM_LD-1:0] ld_act_next;

  logic hrst_fall, blanked, at_index, at_data, in_win, ld_ok;
  logic [LDW-1:0] ld_sel;
  logic [cfgkp_pkg::LDWIN_AW-1:0] win_idx;
  logic [15:0] base_sel;
  logic [7:0]  cur_data;
  logic [7:0]  win_ofs;

  // Decode of the current access
  always_comb begin
    hrst_fall = hrst_prev_reg && !hrst_lvl_reg;
    blanked   = (blank_reg != '0) || !hrst_lvl_reg;
    at_index  = (io_addr_i == base_reg);
    at_data   = (io_addr_i == 16'(base_reg + cfgkp_pkg::DATA_PORT_OFS));
    ld_ok     = (ldn_reg < 8'(NUM_LD));
    ld_sel    = ldn_reg[LDW-1:0];
    win_ofs   = 8'(index_reg - cfgkp_pkg::IDX_LDWIN_BASE);
    in_win    = (index_reg >= cfgkp_pkg::IDX_LDWIN_BASE) && (win_ofs < 8'(WN));
    win_idx   = win_ofs[cfgkp_pkg::LDWIN_AW-1:0];
    base_sel  = strap_cap_next ? cfgkp_pkg::BASE_STRAP1 : cfgkp_pkg::BASE_STRAP0;
    // Register behind the data port
    cur_data = cfgkp_pkg::BYTE_ZERO;
    if (index_reg < cfgkp_pkg::IDX_LD_FIRST) begin
      case (index_reg)
        cfgkp_pkg::IDX_LDN:      cur_data = ldn_reg;
        cfgkp_pkg::IDX_DEV_ID:   cur_data = DEV_ID_VAL;
        cfgkp_pkg::IDX_DEV_REV:  cur_data = DEV_REV_VAL;
        cfgkp_pkg::IDX_PWR_CTRL: cur_data = pwr_ctrl_reg;
        cfgkp_pkg::IDX_PWR_MGMT: cur_data = pwr_mgmt_reg;
        cfgkp_pkg::IDX_OSC:      cur_data = osc_reg;
        cfgkp_pkg::IDX_BASE_LO:  cur_data = base_reg[7:0];
        cfgkp_pkg::IDX_BASE_HI:  cur_data = base_reg[15:8];
        default:                 cur_data = cfgkp_pkg::BYTE_ZERO;
      endcase
    end else if (ld_ok && index_reg == cfgkp_pkg::IDX_ACTIVATE) begin
      cur_data = act_reg[ld_sel];
    end else if (ld_ok && in_win) begin
      cur_data = win_reg[ld_sel][win_idx];
    end
  end

  // Next values of the configuration state
  always_comb begin
    state_next     = state_reg;
    blank_next     = blank_reg;
    strap_cap_next = strap_cap_reg;
    base_next      = base_reg;
    index_next     = index_reg;
    ldn_next       = ldn_reg;
    pwr_ctrl_next  = pwr_ctrl_reg;
    pwr_mgmt_next  = pwr_mgmt_reg;
    osc_next       = osc_reg;
    act_next       = act_reg;
    win_next       = win_reg;
    ack_next       = 1'b0;
    rdata_next     = cfgkp_pkg::BYTE_ZERO;
    if (blank_reg != '0) begin
      blank_next     = CW'(blank_reg - 1'b1);
      strap_cap_next = strap_lvl_reg;
    end else if (hrst_fall) begin
      strap_cap_next = strap_lvl_reg;
    end
    if (blanked) begin
      // Hard reset held or power-on blanking: back to run, devices off
      state_next    = cfgkp_pkg::CFGKP_RUN;
      base_next     = base_sel;
      index_next    = cfgkp_pkg::BYTE_ZERO;
      ldn_next      = cfgkp_pkg::BYTE_ZERO;
      pwr_ctrl_next = cfgkp_pkg::BYTE_ZERO;
      pwr_mgmt_next = cfgkp_pkg::BYTE_ZERO;
      osc_next      = cfgkp_pkg::OSC_RST;
      for (int i = 0; i < NUM_LD; i++) begin
        act_next[i] = cfgkp_pkg::BYTE_ZERO;
        for (int j = 0; j < WN; j++) begin
          win_next[i][j] = cfgkp_pkg::BYTE_ZERO;
        end
      end
    end else begin
      case (state_reg)
        cfgkp_pkg::CFGKP_RUN: begin
          // Only the unlock key at the index port counts; all else ignored
          if (io_wr_i && at_index && io_wdata_i == cfgkp_pkg::KEY_UNLOCK) begin
            state_next = cfgkp_pkg::CFGKP_CFG;
            ack_next   = 1'b1;
          end
        end
        cfgkp_pkg::CFGKP_CFG: begin
          if (io_wr_i && at_index) begin
            ack_next = 1'b1;
            if (io_wdata_i == cfgkp_pkg::KEY_LOCK) begin
              state_next = cfgkp_pkg::CFGKP_RUN;
            end else begin
              index_next = io_wdata_i;
            end
          end else if (io_rd_i && at_index) begin
            ack_next   = 1'b1;
            rdata_next = index_reg;
          end else if (io_rd_i && at_data) begin
            ack_next   = 1'b1;
            rdata_next = cur_data;
          end else if (io_wr_i && at_data) begin
            ack_next = 1'b1;
            if (index_reg < cfgkp_pkg::IDX_LD_FIRST) begin
              case (index_reg)
                cfgkp_pkg::IDX_LDN:      ldn_next = io_wdata_i;
                cfgkp_pkg::IDX_PWR_CTRL: pwr_ctrl_next = io_wdata_i;
                cfgkp_pkg::IDX_PWR_MGMT: pwr_mgmt_next = io_wdata_i;
                cfgkp_pkg::IDX_OSC:      osc_next = io_wdata_i;
                cfgkp_pkg::IDX_BASE_LO:  base_next[7:0] = io_wdata_i;
                cfgkp_pkg::IDX_BASE_HI:  base_next[15:8] = io_wdata_i;
                cfgkp_pkg::IDX_CFG_CTRL: begin
                  // Soft reset; port base, power management and oscillator registers survive
                  if (io_wdata_i[cfgkp_pkg::SOFT_RST_BIT]) begin
                    ldn_next      = cfgkp_pkg::BYTE_ZERO;
                    pwr_ctrl_next = cfgkp_pkg::BYTE_ZERO;
                    for (int i = 0; i < NUM_LD; i++) begin
                      act_next[i] = cfgkp_pkg::BYTE_ZERO;
                      for (int j = 0; j < WN; j++) begin
                        win_next[i][j] = cfgkp_pkg::BYTE_ZERO;
                      end
                    end
                  end
                end
                default: ;
              endcase
            end else if (ld_ok && index_reg == cfgkp_pkg::IDX_ACTIVATE) begin
              act_next[ld_sel] = io_wdata_i;
            end else if (ld_ok && in_win) begin
              win_next[ld_sel][win_idx] = io_wdata_i;
            end
          end
        end
        default: state_next = cfgkp_pkg::CFGKP_RUN;
      endcase
    end
    for (int i = 0; i < NUM_LD; i++) begin
      ld_act_next[i] = act_next[i][cfgkp_pkg::ACTIVATE_BIT];
    end
  end

  // Registers of the configuration state
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg     <= cfgkp_pkg::CFGKP_RUN;
      blank_reg     <= CW'(BLANK_CYC);
      strap_cap_reg <= 1'b0;
      hrst_prev_reg <= 1'b1;
      base_reg      <= cfgkp_pkg::BASE_STRAP0;
      index_reg     <= cfgkp_pkg::BYTE_ZERO;
      ldn_reg       <= cfgkp_pkg::BYTE_ZERO;
      pwr_ctrl_reg  <= cfgkp_pkg::BYTE_ZERO;
      pwr_mgmt_reg  <= cfgkp_pkg::BYTE_ZERO;
      osc_reg       <= cfgkp_pkg::OSC_RST;
      for (int i = 0; i < NUM_LD; i++) begin
        act_reg[i] <= cfgkp_pkg::BYTE_ZERO;
        for (int j = 0; j < WN; j++) begin
          win_reg[i][j] <= cfgkp_pkg::BYTE_ZERO;
        end
      end
      io_ack_o      <= 1'b0;
      io_rdata_o    <= cfgkp_pkg::BYTE_ZERO;
      cfg_mode_o    <= 1'b0;
      cfg_base_o    <= cfgkp_pkg::BASE_STRAP0;
      ld_active_o   <= '0;
    end else begin
      state_reg     <= state_next;
      blank_reg     <= blank_next;
      strap_cap_reg <= strap_cap_next;
      hrst_prev_reg <= hrst_lvl_reg;
      base_reg      <= base_next;
      index_reg     <= index_next;
      ldn_reg       <= ldn_next;
      pwr_ctrl_reg  <= pwr_ctrl_next;
      pwr_mgmt_reg  <= pwr_mgmt_next;
      osc_reg       <= osc_next;
      act_reg       <= act_next;
      win_reg       <= win_next;
      io_ack_o      <= ack_next;
      io_rdata_o    <= rdata_next;
      cfg_mode_o    <= (state_next == cfgkp_pkg::CFGKP_CFG);
      cfg_base_o    <= base_next;
      ld_active_o   <= ld_act_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence unlock_s;
    !blanked && state_reg == cfgkp_pkg::CFGKP_RUN && io_wr_i && at_index
      && io_wdata_i == cfgkp_pkg::KEY_UNLOCK;
  endsequence
  sequence lock_s;
    !blanked && state_reg == cfgkp_pkg::CFGKP_CFG && io_wr_i && at_index
      && io_wdata_i == cfgkp_pkg::KEY_LOCK;
  endsequence

  hard_rst_run_a: assert property (!hrst_lvl_reg |=> !cfg_mode_o && ld_active_o == '0)
    else $error("hard reset left config state or a device active");
  run_port_quiet_a: assert property (state_reg == cfgkp_pkg::CFGKP_RUN && io_rd_i
    |=> !io_ack_o && io_rdata_o == cfgkp_pkg::BYTE_ZERO)
    else $error("port answered a read in run state");
  // Strap level seen at the hard reset fall picks the base one cycle later
  strap_base_a: assert property (hrst_fall |=> cfg_base_o ==
    ($past(strap_lvl_reg) ? cfgkp_pkg::BASE_STRAP1 : cfgkp_pkg::BASE_STRAP0))
    else $error("port base does not follow the strap");
  base_low_wr_a: assert property (!blanked && state_reg == cfgkp_pkg::CFGKP_CFG
    && io_wr_i && at_data && !at_index && index_reg == cfgkp_pkg::IDX_BASE_LO
    |=> cfg_base_o[7:0] == $past(io_wdata_i))
    else $error("base low byte not written");
  unlock_enter_a: assert property (unlock_s |=> cfg_mode_o && io_ack_o)
    else $error("unlock key did not enter config state");
  lock_exit_a: assert property (lock_s |=> !cfg_mode_o ##1 !cfg_mode_o || $past(io_wr_i))
    else $error("lock key did not return to run state");
  index_load_a: assert property (!blanked && state_reg == cfgkp_pkg::CFGKP_CFG
    && io_wr_i && at_index && io_wdata_i != cfgkp_pkg::KEY_LOCK
    |=> index_reg == $past(io_wdata_i))
    else $error("index port write not taken");
  // Hard reset may legally clear the index, so blanked cycles are left out
  run_ignore_a: assert property (!blanked && state_reg == cfgkp_pkg::CFGKP_RUN
    && io_wr_i && io_wdata_i != cfgkp_pkg::KEY_UNLOCK |=> !cfg_mode_o && $stable(index_reg))
    else $error("run state reacted to a non-key write");
  blank_quiet_a: assert property (blank_reg != '0 |=> !io_ack_o)
    else $error("host access answered during blanking");
  soft_rst_a: assert property (!blanked && state_reg == cfgkp_pkg::CFGKP_CFG
    && io_wr_i && at_data && !at_index && index_reg == cfgkp_pkg::IDX_CFG_CTRL
    && io_wdata_i[cfgkp_pkg::SOFT_RST_BIT] |=> ldn_reg == '0 && ld_active_o == '0)
    else $error("soft reset did not clear configuration");
endmodule : cfgkp_top

// file: test/cfgkp_host_model.sv
module cfgkp_host_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Host I/O cycles
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic [15:0]      io_addr_o,
  output logic [7:0]       io_wdata_o,
  input  wire logic        io_ack_i,
  input  wire logic [7:0]  io_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle at time zero
  initial begin
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = 16'h0000;
    io_wdata_o = 8'h00;
  end

  // One pulsed I/O cycle; answer looked for in the two cycles after it
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                      output logic acked, output logic [7:0] rd);
    @(negedge clk_sys_i);
    io_wr_o    = wr;
    io_rd_o    = ~wr;
    io_addr_o  = addr;
    io_wdata_o = data;
    @(negedge clk_sys_i);
    // Released lines show the inverse, never a stale match
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = ~addr;
    io_wdata_o = ~data;
    acked      = io_ack_i;
    rd         = io_rdata_i;
    if (acked !== 1'b1) begin
      @(negedge clk_sys_i);
      acked = io_ack_i;
      rd    = io_rdata_i;
    end
  endtask : xfer

  // Device number first, then register index within it
  task automatic sel(input logic [15:0] base, input logic [7:0] ldn, input logic [7:0] idx);
    logic       a;
    logic [7:0] r;
    xfer(1'b1, base, cfgkp_pkg::IDX_LDN, a, r);
    xfer(1'b1, base + 16'h0001, ldn, a, r);
    xfer(1'b1, base, idx, a, r);
  endtask : sel
endmodule : cfgkp_host_model

// file: test/cfgkp_tb_top.sv
module cfgkp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         NLD   = 10;
  localparam int         BLNK  = 20;
  localparam logic [7:0] ID_V  = 8'hA5; // Arbitrary value
  localparam logic [7:0] REV_V = 8'h01; // Arbitrary value
  localparam logic [15:0] B0   = cfgkp_pkg::BASE_STRAP0;
  localparam logic [15:0] B1   = cfgkp_pkg::BASE_STRAP1;
  logic             clk_sys_i;
  logic             nrst_i;
  logic             hard_rst_n;
  logic             strap;
  logic             io_wr;
  logic             io_rd;
  logic [15:0]      io_addr;
  logic [7:0]       io_wdata;
  logic             io_ack;
  logic [7:0]       io_rdata;
  logic             cfg_mode;
  logic [15:0]      cfg_base;
  logic [NLD-1:0]   ld_active;
  int               n_fail;
  int               checks_done;
  logic             acked;
  logic [7:0]       rd;

  // 200 MHz clock
  initial clk_sys_i = 1'b0;
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Block and host
  cfgkp_top #(.NUM_LD(NLD), .BLANK_CYC(BLNK), .DEV_ID_VAL(ID_V), .DEV_REV_VAL(REV_V)) u_cfgkp_top (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hard_rst_n_i(hard_rst_n), .base_strap_i(strap),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_ack_o(io_ack), .io_rdata_o(io_rdata), .cfg_mode_o(cfg_mode), .cfg_base_o(cfg_base),
    .ld_active_o(ld_active));
  cfgkp_host_model u_cfgkp_host_model (
    .clk_sys_i(clk_sys_i), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_addr),
    .io_wdata_o(io_wdata), .io_ack_i(io_ack), .io_rdata_i(io_rdata));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Host access helpers
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    u_cfgkp_host_model.xfer(wr, a, d, acked, rd);
  endtask : io
  task automatic wreg(input logic [15:0] b, input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, b, idx);
    io(1'b1, b + 16'h0001, d);
  endtask : wreg
  task automatic rreg(input logic [15:0] b, input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, b, idx);
    io(1'b0, b + 16'h0001, 8'h00);
    chk("reg_read", 16'(rd), 16'(exp));
  endtask : rreg

  // Reset values and power-on blanking
  task automatic t_reset();
    chk("mode", 16'(cfg_mode), 16'h0000);
    chk("active", 16'(ld_active), 16'h0000);
    io(1'b1, B0, cfgkp_pkg::KEY_UNLOCK);
    chk("blank_ack", 16'(acked), 16'h0000);
    chk("blank_mode", 16'(cfg_mode), 16'h0000);
    repeat (BLNK + 4) @(negedge clk_sys_i);
    chk("base", cfg_base, B0);
    $display("done reset");
  endtask : t_reset

  // Run state ignores all but the unlock key written at the base
  task automatic t_run_ignore();
    logic [15:0] at[4] = '{B0, B0, B0 + 16'h0001, B0 + 16'h0001};
    logic [7:0]  dt[4] = '{cfgkp_pkg::KEY_LOCK, cfgkp_pkg::IDX_LDN, cfgkp_pkg::KEY_UNLOCK, 8'h01};
    for (int i = 0; i < 4; i++) begin
      io(1'b1, at[i], dt[i]);
      chk("run_ack", 16'(acked), 16'h0000);
      chk("run_mode", 16'(cfg_mode), 16'h0000);
      io(1'b0, at[i], 8'h00);
      chk("run_rd_ack", 16'(acked), 16'h0000);
    end
    $display("done run_ignore");
  endtask : t_run_ignore

  // Unlock, select devices, activate, read back, lock
  task automatic t_walk();
    io(1'b1, B0, cfgkp_pkg::KEY_UNLOCK);
    chk("unlock_ack", 16'(acked), 16'h0001);
    chk("unlock_mode", 16'(cfg_mode), 16'h0001);
    u_cfgkp_host_model.sel(B0, 8'h03, cfgkp_pkg::IDX_ACTIVATE);
    io(1'b1, B0 + 16'h0001, 8'h01);
    chk("active3", 16'(ld_active), 16'h0008);
    io(1'b0, B0 + 16'h0001, 8'h00);
    chk("act_rd", 16'(rd), 16'h0001);
    io(1'b0, B0, 8'h00);
    chk("index_rd", 16'(rd), 16'(cfgkp_pkg::IDX_ACTIVATE));
    u_cfgkp_host_model.sel(B0, 8'h05, cfgkp_pkg::IDX_LDWIN_BASE);
    io(1'b1, B0 + 16'h0001, 8'h5A);
    rreg(B0, cfgkp_pkg::IDX_LDWIN_BASE, 8'h5A);
    u_cfgkp_host_model.sel(B0, 8'h03, cfgkp_pkg::IDX_LDWIN_BASE);
    io(1'b0, B0 + 16'h0001, 8'h00);
    chk("other_dev", 16'(rd), 16'h0000);
    io(1'b1, B0, cfgkp_pkg::KEY_LOCK);
    chk("lock_mode", 16'(cfg_mode), 16'h0000);
    io(1'b0, B0 + 16'h0001, 8'h00);
    chk("locked_ack", 16'(acked), 16'h0000);
    $display("done walk");
  endtask : t_walk

  // Globals without device selection, then soft reset
  task automatic t_glob_soft();
    io(1'b1, B0, cfgkp_pkg::KEY_UNLOCK);
    rreg(B0, cfgkp_pkg::IDX_DEV_ID, ID_V);
    rreg(B0, cfgkp_pkg::IDX_DEV_REV, REV_V);
    rreg(B0, cfgkp_pkg::IDX_OSC, cfgkp_pkg::OSC_RST);
    wreg(B0, cfgkp_pkg::IDX_PWR_CTRL, 8'h3C);
    rreg(B0, cfgkp_pkg::IDX_PWR_CTRL, 8'h3C);
    wreg(B0, cfgkp_pkg::IDX_OSC, 8'h11);
    wreg(B0, cfgkp_pkg::IDX_CFG_CTRL, 8'h01);
    chk("soft_active", 16'(ld_active), 16'h0000);
    rreg(B0, cfgkp_pkg::IDX_LDN, 8'h00);
    rreg(B0, cfgkp_pkg::IDX_PWR_CTRL, 8'h00);
    rreg(B0, cfgkp_pkg::IDX_OSC, 8'h11);
    $display("done glob_soft");
  endtask : t_glob_soft

  // Move the port base, then lock at the new place
  task automatic t_reloc();
    u_cfgkp_host_model.sel(B0, 8'h01, cfgkp_pkg::IDX_ACTIVATE);
    io(1'b1, B0 + 16'h0001, 8'h01);
    wreg(B0, cfgkp_pkg::IDX_BASE_LO, 8'h60);
    chk("base_lo", cfg_base, 16'h0060);
    io(1'b0, B0, 8'h00);
    chk("old_base", 16'(acked), 16'h0000);
    rreg(16'h0060, cfgkp_pkg::IDX_BASE_LO, 8'h60);
    wreg(16'h0060, cfgkp_pkg::IDX_BASE_HI, 8'h01);
    chk("base_hi", cfg_base, 16'h0160);
    io(1'b1, 16'h0160, cfgkp_pkg::KEY_LOCK);
    chk("reloc_lock", 16'(cfg_mode), 16'h0000);
    $display("done reloc");
  endtask : t_reloc

  // Hard reset pin captures the strap on its falling edge
  task automatic t_hard();
    strap = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    hard_rst_n = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    hard_rst_n = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("hr_base", cfg_base, B1);
    chk("hr_active", 16'(ld_active), 16'h0000);
    strap = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk("strap_held", cfg_base, B1);
    io(1'b1, B1, cfgkp_pkg::KEY_UNLOCK);
    chk("hr_unlock", 16'(cfg_mode), 16'h0001);
    rreg(B1, cfgkp_pkg::IDX_BASE_LO, 8'h4E);
    io(1'b1, B1, cfgkp_pkg::KEY_LOCK);
    chk("hr_lock", 16'(cfg_mode), 16'h0000);
    $display("done hard");
  endtask : t_hard

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    n_fail      = 0;
    checks_done = 0;
    nrst_i      = 1'b0;
    hard_rst_n  = 1'b1;
    strap       = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    t_reset();
    t_run_ignore();
    t_walk();
    t_glob_soft();
    t_reloc();
    t_hard();
    close_out();
  end
endmodule : cfgkp_tb_top
